// [ee_access.sv]
/*
  i2c slave access engine for a 256-byte serial eeprom.
  assumes scl, sda and the supervisor reset are asynchronous pins;
  sda is open drain, resolved outside from sdaOut and sdaOe.
*/
// Notes on behaviour
// [RQ1] write address byte loads the pointer, acked
// [RQ2] data byte acked; stop starts programming
// [RQ3] while programming, nothing is acknowledged
// [RQ4] page write takes up to sixteen bytes
// [RQ5] write bytes bump only the page offset
// [RQ6] over sixteen bytes wrap and overwrite
// [RQ7] all buffered bytes program in one cycle
// [RQ8] address polling acked only when idle
// [RQ9] direction bit one starts the read forms
// [RQ10] pointer holds last address plus one
// [RQ11] current read sends byte at the pointer
// [RQ12] dummy write then restart gives random read
// [RQ13] master ack asks for the next byte
// [RQ14] reads increment the full pointer
// [RQ15] upper four address bits must match type
// [RQ16] address lsb one reads, zero writes
// [RQ17] supervisor reset aborts and refuses traffic
// [RQ18] page offset is pointer low four bits
`timescale 1ns/1ps
module ee_access #(
  parameter int WR_CNT = ee_pkg::WR_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic supRstIn,
  output logic      busyOut
);
  import ee_pkg::*;
  // ************************************************************
  // pin synchronisers and edge finding
  // ************************************************************
  logic [2:0] sclSy_r, sdaSy_r;
  logic [1:0] supSy_r;
  logic       sclRise, sclFall, startEv, stopEv, supRst;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclSy_r <= 3'h7;
      sdaSy_r <= 3'h7;
      supSy_r <= 2'h0;
    end else begin
      sclSy_r <= {sclSy_r[1:0], sclIn};
      sdaSy_r <= {sdaSy_r[1:0], sdaIn};
      supSy_r <= {supSy_r[0], supRstIn};
    end
  end

  // stage 0 only feeds stage 1; edges use stages 1 and 2
  assign sclRise = sclSy_r[1] && !sclSy_r[2];
  assign sclFall = !sclSy_r[1] && sclSy_r[2];
  assign startEv = sclSy_r[1] && sclSy_r[2] && sdaSy_r[2] && !sdaSy_r[1];
  assign stopEv  = sclSy_r[1] && sclSy_r[2] && !sdaSy_r[2] && sdaSy_r[1];
  assign supRst  = supSy_r[1];

  // ************************************************************
  // array and write buffer
  // ************************************************************
  ee_nvm_if nvm ();

  logic              pushValid, pushReady;
  logic [FIFO_W-1:0] pushWord;

  ee_fifo2 #(.W(FIFO_W)) uBuf (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (nvm.wValid),
    .outReady (nvm.wReady),
    .outData  (nvm.wWord)
  );

  ee_array #(.WR_CNT(WR_CNT)) uArr (
    .clk (clk),
    .rst (rst),
    .nvm (nvm.mem)
  );

  // ************************************************************
  // bus engine
  // ************************************************************
  ee_state_t         state_r, state_nxt;
  logic [2:0]        bitCnt_r, bitCnt_nxt;
  logic              full_r, full_nxt;
  logic [DATA_W-1:0] shift_r, shift_nxt;
  logic [DATA_W-1:0] tx_r, tx_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic              dirty_r, dirty_nxt;
  logic              mAck_r, mAck_nxt;
  logic              oe_r, oe_nxt;
  logic              commit;
  logic              devHit;

  function automatic logic isRecv(input ee_state_t s);
    return s == ST_DEV || s == ST_WA || s == ST_WD;
  endfunction : isRecv

  // busy check covers address polling as well as every other request
  assign devHit     = (shift_r[7:4] == DEV_TYPE) && !nvm.busy && !supRst; // [RQ15] [RQ3] [RQ8]
  assign nvm.rdAddr = ptr_r;
  assign nvm.commit = commit;
  assign nvm.drop   = supRst; // [RQ17]
  assign pushWord   = {ptr_r, shift_r};

  always_comb begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    full_nxt   = full_r;
    shift_nxt  = shift_r;
    tx_nxt     = tx_r;
    ptr_nxt    = ptr_r;
    dirty_nxt  = dirty_r;
    mAck_nxt   = mAck_r;
    oe_nxt     = oe_r;
    commit     = 1'b0;
    pushValid  = 1'b0;
    if (supRst) begin // [RQ17]
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
      dirty_nxt = 1'b0;
    end else if (stopEv) begin
      // a lone address byte (dummy write, polling) programs nothing
      commit    = dirty_r; // [RQ2] [RQ7]
      dirty_nxt = 1'b0;
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else if (startEv) begin
      state_nxt  = ST_DEV;
      bitCnt_nxt = 3'h0;
      full_nxt   = 1'b0;
      oe_nxt     = 1'b0;
    end else if (sclRise && isRecv(state_r) && !full_r) begin
      shift_nxt  = {shift_r[DATA_W-2:0], sdaSy_r[1]};
      bitCnt_nxt = bitCnt_r + 3'h1;
      full_nxt   = (bitCnt_r == BIT_LAST);
    end else if (sclRise && state_r == ST_RDACK) begin
      mAck_nxt = !sdaSy_r[1];
    end else if (sclFall) begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_DEV: begin
          if (full_r) begin
            state_nxt = devHit ? ST_DEVACK : ST_IDLE;
            oe_nxt    = devHit;
          end
        end
        ST_DEVACK: begin
          if (shift_r[0]) begin // [RQ16] [RQ9] [RQ11]
            tx_nxt    = nvm.rdData;
            oe_nxt    = !nvm.rdData[DATA_W-1];
            ptr_nxt   = ptr_r + 8'h01; // [RQ14] [RQ10]
            state_nxt = ST_RD;
          end else begin
            oe_nxt    = 1'b0;
            state_nxt = ST_WA;
          end
          bitCnt_nxt = 3'h0;
          full_nxt   = 1'b0;
        end
        ST_WA: begin
          if (full_r) begin
            ptr_nxt   = shift_r; // [RQ1] [RQ12]
            oe_nxt    = 1'b1;
            state_nxt = ST_WAACK;
          end
        end
        ST_WD: begin
          if (full_r) begin
            // a full buffer withholds ack, so the master sees the stall
            if (pushReady) begin // [RQ2] [RQ4]
              pushValid     = 1'b1;
              ptr_nxt[3:0]  = ptr_r[3:0] + 4'h1; // [RQ5] [RQ18] [RQ6]
              dirty_nxt     = 1'b1;
              oe_nxt        = 1'b1;
              state_nxt     = ST_WDACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_WAACK, ST_WDACK: begin
          oe_nxt     = 1'b0;
          bitCnt_nxt = 3'h0;
          full_nxt   = 1'b0;
          state_nxt  = ST_WD;
        end
        ST_RD: begin
          if (bitCnt_r == BIT_LAST) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_RDACK;
          end else begin
            bitCnt_nxt = bitCnt_r + 3'h1;
            tx_nxt     = {tx_r[DATA_W-2:0], 1'b0};
            oe_nxt     = !tx_r[DATA_W-2];
          end
        end
        ST_RDACK: begin
          if (mAck_r) begin // [RQ13]
            tx_nxt     = nvm.rdData;
            oe_nxt     = !nvm.rdData[DATA_W-1];
            ptr_nxt    = ptr_r + 8'h01; // [RQ14]
            bitCnt_nxt = 3'h0;
            state_nxt  = ST_RD;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    shift_r <= shift_nxt;
    tx_r    <= tx_nxt;
    mAck_r  <= mAck_nxt;
    if (rst) begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 3'h0;
      full_r   <= 1'b0;
      ptr_r    <= PTR_RST;
      dirty_r  <= 1'b0;
      oe_r     <= 1'b0;
      sdaOut   <= 1'b0;
      sdaOe    <= 1'b0;
      busyOut  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      full_r   <= full_nxt;
      ptr_r    <= ptr_nxt;
      dirty_r  <= dirty_nxt;
      oe_r     <= oe_nxt;
      sdaOut   <= 1'b0;
      sdaOe    <= oe_nxt;
      busyOut  <= nvm.busy;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_writeAck;
    state_r == ST_WD && sclFall && full_r && pushReady && !stopEv && !startEv && !supRst;
  endsequence

  a_busy_no_ack: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    nvm.busy && state_r == ST_DEV |=> state_r != ST_DEVACK)
    else $error("address acknowledged while programming");
  a_page_offset: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    s_writeAck |=> ptr_r[7:4] == $past(ptr_r[7:4]) && ptr_r[3:0] == $past(ptr_r[3:0]) + 4'h1)
    else $error("write pointer step wrong");
  a_write_ack: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    s_writeAck |=> sdaOe ##0 state_r == ST_WDACK)
    else $error("data byte not acknowledged");
  a_read_step: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    state_r == ST_RDACK && sclFall && mAck_r && !stopEv && !startEv && !supRst
    |=> ptr_r == $past(ptr_r) + 8'h01 && state_r == ST_RD)
    else $error("read pointer did not advance");
  a_type_match: assert property (@(posedge clk) disable iff (rst) // [RQ15]
    $rose(state_r == ST_DEVACK) |-> shift_r[7:4] == DEV_TYPE && sdaOe)
    else $error("ack on foreign type code");
  a_word_load: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    $rose(state_r == ST_WAACK) |-> ptr_r == shift_r)
    else $error("word address not loaded");
  a_dir_select: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    $rose(state_r == ST_RD) && $past(state_r) == ST_DEVACK |-> shift_r[0])
    else $error("read begun without direction bit");
  a_sup_abort: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    supRst |=> state_r == ST_IDLE && !sdaOe && !commit)
    else $error("traffic survived supervisor reset");
  a_stop_commit: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    stopEv && dirty_r && !supRst && !nvm.busy |=> ##1 busyOut)
    else $error("stop after data did not start programming");
endmodule : ee_access

// [ee_pkg.sv]
/*
  constants shared by the serial eeprom access engine.
  assumes a 200 MHz system clock and a 256-byte array with 16-byte pages.
*/
package ee_pkg;
  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          PAGE_W      = 4;
  localparam int          PAGE_BYTES  = 16;
  localparam int          MEM_BYTES   = 256;
  localparam int          FIFO_W      = ADDR_W + DATA_W;
  // ************************************************************
  // addressing
  // ************************************************************
  // device type code: value is arbitrary
  localparam logic [3:0]  DEV_TYPE    = 4'h5;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [7:0]  PTR_RST     = 8'h00;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_MHZ     = 200;
  localparam int          T_WR_US     = 5000;
  localparam int          WR_CYCLES   = T_WR_US * CLK_MHZ;
  localparam int          CNT_W       = 32;
  // ************************************************************
  // bus engine states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEVACK, ST_WA, ST_WAACK, ST_WD, ST_WDACK, ST_RD, ST_RDACK
  } ee_state_t;
endpackage : ee_pkg

// [ee_nvm_if.sv]
/*
  link between the bus engine and the array: write stream, commit, read port.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ee_nvm_if;
  import ee_pkg::*;
  logic                   wValid;
  logic                   wReady;
  logic [FIFO_W-1:0]      wWord;
  logic                   commit;
  logic                   drop;
  logic                   busy;
  logic [ADDR_W-1:0]      rdAddr;
  logic [DATA_W-1:0]      rdData;
  modport ctl (output commit, drop, rdAddr, input busy, rdData);
  modport mem (input wValid, wWord, commit, drop, rdAddr, output wReady, busy, rdData);
  modport buf_out (output wValid, wWord, input wReady);
endinterface : ee_nvm_if

// [ee_fifo2.sv]
/*
  two-entry valid/ready buffer.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module ee_fifo2 #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic [1:0]   cnt_r, cnt_nxt;
  logic         rdp_r, rdp_nxt, wrp_r, wrp_nxt;
  logic         push, pop;

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = mem_r[rdp_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wrp_r] = inData;
    end
    wrp_nxt = push ? ~wrp_r : wrp_r;
    rdp_nxt = pop ? ~rdp_r : rdp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
    if (rst) begin
      cnt_r <= 2'h0;
      rdp_r <= 1'b0;
      wrp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      rdp_r <= rdp_nxt;
      wrp_r <= wrp_nxt;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    cnt_r != 2'h3)
    else $error("fifo count past two entries");
endmodule : ee_fifo2

// [ee_array.sv]
/*
  256-byte array with 16-byte page buffer and timed programming cycle.
  assumes commit arrives only while idle; supervisor reset never stops a cycle.
*/
`timescale 1ns/1ps
module ee_array #(
  parameter int WR_CNT = ee_pkg::WR_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  ee_nvm_if.mem     nvm
);
  import ee_pkg::*;
  logic [DATA_W-1:0] mem_r [MEM_BYTES];
  logic [DATA_W-1:0] page_r [PAGE_BYTES];
  logic [DATA_W-1:0] page_nxt [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic [PAGE_W-1:0]     hi_r, hi_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic                  busy_r, busy_nxt, done;
  logic [DATA_W-1:0]     rd_r;

  assign nvm.wReady = !busy_r;
  assign nvm.busy   = busy_r;
  assign nvm.rdData = rd_r;
  assign done       = busy_r && (cnt_r == CNT_W'(1));

  always_comb begin
    page_nxt = page_r;
    mask_nxt = mask_r;
    hi_nxt   = hi_r;
    busy_nxt = busy_r;
    cnt_nxt  = busy_r ? cnt_r - CNT_W'(1) : cnt_r;
    // later bytes at one offset replace earlier ones
    if (nvm.wValid && !busy_r) begin // [RQ6]
      page_nxt[nvm.wWord[DATA_W +: PAGE_W]] = nvm.wWord[DATA_W-1:0];
      mask_nxt[nvm.wWord[DATA_W +: PAGE_W]] = 1'b1;
      hi_nxt = nvm.wWord[FIFO_W-1 -: PAGE_W];
    end
    // an aborted frame must leave nothing for the next commit
    if (nvm.drop && !busy_r) begin // [RQ17]
      mask_nxt = '0;
    end
    if (nvm.commit && !busy_r) begin // [RQ2]
      busy_nxt = 1'b1;
      cnt_nxt  = CNT_W'(WR_CNT);
    end
    if (done) begin
      busy_nxt = 1'b0;
      mask_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    rd_r   <= mem_r[nvm.rdAddr];
    page_r <= page_nxt;
    hi_r   <= hi_nxt;
    cnt_r  <= cnt_nxt;
    // buffered page bytes land in one cycle at the end of programming
    if (done) begin // [RQ7]
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem_r[{hi_r, PAGE_W'(i)}] <= page_r[i];
        end
      end
    end
    if (rst) begin
      mask_r <= '0;
      busy_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      busy_r <= busy_nxt;
    end
  end

  a_commit_busy: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    nvm.commit && !busy_r |=> busy_r [*2])
    else $error("commit did not start programming");
  a_drop_clear: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    nvm.drop && !busy_r |=> mask_r == '0)
    else $error("aborted page bytes kept");
endmodule : ee_array

// [ee_i2c_master.sv]
/*
  behavioural bus master that drives the eeprom access engine: start, stop, bytes.
  assumes a pull-up on the data wire and the bench clock as its time base.
*/
`timescale 1ns/1ps
module ee_i2c_master (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      sclDrv,
  output logic      sdaDrv
);
  // bus clock idles high, data released; 16 clk per bit gives 80 ns
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w

  // clock is lowered first so a held ack is let go before data rises
  // data falls while clock high; also serves as repeated start
  task automatic start();
    sclDrv = 1'b0;
    w(4);
    sdaDrv = 1'b1;
    w(4);
    sclDrv = 1'b1;
    w(8);
    sdaDrv = 1'b0;
    w(8);
  endtask : start

  // data rises while clock high; every frame ends here
  task automatic stop();
    sclDrv = 1'b0;
    w(4);
    sdaDrv = 1'b0;
    w(4);
    sclDrv = 1'b1;
    w(8);
    sdaDrv = 1'b1;
    w(8);
  endtask : stop

  // data changes mid-low, sampled mid-high, well clear of both edges
  task automatic xbit(input logic b, output logic r);
    sclDrv = 1'b0;
    w(4);
    sdaDrv = b;
    w(4);
    sclDrv = 1'b1;
    w(4);
    r = sdaLine;
    w(4);
  endtask : xbit

  // msb first, ninth clock returns the device ack
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask : wrByte

  // master ack asks for more, nack ends the read
  task automatic rdByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(~more, r);
  endtask : rdByte
endmodule : ee_i2c_master

// [tb_ee_access.sv]
/*
  self-checking bench for the eeprom access engine with a bus master model.
  assumes WR_CNT is shortened so each programming cycle lasts WR_T clocks.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  numChecks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module tb_ee_access;
  import ee_pkg::*;
  localparam int WR_T = 400;
  logic       clk;
  logic       rst;
  logic       sclDrv;
  logic       sdaDrv;
  logic       sdaLine;
  logic       sdaOut;
  logic       sdaOe;
  logic       supRstIn;
  logic       busyOut;
  logic       busyPrev;
  logic       ack;
  logic [7:0] d;
  logic [7:0] a;
  logic [7:0] refPtr;
  logic [7:0] refMem [MEM_BYTES];
  logic [7:0] wa [4];
  int         n;
  int         seed;
  int         failures;
  int         numChecks;
  int         busyRises;

  // ************************************************************
  // clock, wire and instances
  // ************************************************************
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // pull-up: low only when someone pulls
  assign sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);

  ee_access #(.WR_CNT(WR_T)) dut_u (
    .clk(clk), .rst(rst), .sclIn(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .supRstIn(supRstIn), .busyOut(busyOut));
  ee_i2c_master mst_u (.clk(clk), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));

  // count programming cycles to catch a page split into several
  always @(posedge clk) begin
    busyPrev <= busyOut;
    if (rst)
      busyRises <= 0;
    else if (busyOut === 1'b1 && busyPrev !== 1'b1)
      busyRises <= busyRises + 1;
  end

  // ************************************************************
  // transfer helpers
  // ************************************************************
  // write pointer step: offset wraps, page stays
  function automatic logic [7:0] wrNext(input logic [7:0] p);
    return {p[7:4], p[3:0] + 4'h1};
  endfunction : wrNext

  task automatic devAddr(input logic rw);
    mst_u.start();
    mst_u.wrByte({DEV_TYPE, 3'($random(seed)), rw}, ack);
  endtask : devAddr

  // write n bytes from a, then poll; sup holds supervisor reset while busy
  task automatic pageWr(input logic [7:0] a, input int n, input bit sup);
    logic [7:0] p;
    int         r0;
    int         k;
    p = a;
    r0 = busyRises;
    devAddr(1'b0);
    `CHK(ack, 1'b1)
    mst_u.wrByte(a, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      mst_u.wrByte(d, ack);
      `CHK(ack, 1'b1)
      refMem[p] = d;
      p = wrNext(p);
    end
    mst_u.stop();
    refPtr = p;
    mst_u.w(10);
    `CHK(busyOut, 1'b1)
    if (sup) begin
      supRstIn = 1'b1;
      devAddr(1'b0);
      `CHK(ack, 1'b0)
      mst_u.stop();
      mst_u.w(WR_T);
      `CHK(busyOut, 1'b0)
      supRstIn = 1'b0;
      mst_u.w(4);
    end
    k = 0;
    do begin
      devAddr(1'b0);
      mst_u.stop();
      k++;
    end while (ack !== 1'b1 && k < 12);
    `CHK(ack, 1'b1)
    if (!sup) `CHK(k > 1, 1'b1)
    `CHK(busyRises - r0, 1)
  endtask : pageWr

  // optional dummy write to a, then read n bytes in one frame
  task automatic rdSeq(input logic [7:0] a, input bit rnd, input int n);
    if (rnd) begin
      devAddr(1'b0);
      mst_u.wrByte(a, ack);
      `CHK(ack, 1'b1)
      refPtr = a;
    end
    devAddr(1'b1);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      mst_u.rdByte(i < n - 1, d);
      `CHK(d, refMem[refPtr])
      refPtr++;
    end
    mst_u.stop();
  endtask : rdSeq

  task automatic complete_run();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 32'h83f8;
    failures = 0;
    numChecks = 0;
    rst = 1'b1;
    supRstIn = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    mst_u.w(4);
    mst_u.start();
    mst_u.wrByte({~DEV_TYPE, 4'h0}, ack);
    `CHK(ack, 1'b0)
    mst_u.stop();
    wa = '{8'h00, 8'h01, 8'($random(seed)), 8'($random(seed))};
    for (int i = 0; i < 4; i++) begin
      pageWr(wa[i], 1, 1'b0);
      rdSeq(wa[i], 1'b1, 1);
    end
    // start two below the page end: 18 bytes wrap and overwrite
    pageWr(8'hfe, 18, 1'b0);
    rdSeq(8'h00, 1'b0, 1);
    rdSeq(8'hfc, 1'b1, 6);
    a = 8'($random(seed));
    n = 2 + ($random(seed) & 15);
    pageWr(a, n, 1'b0);
    for (int i = 0; i < n && i < PAGE_BYTES; i++) begin
      rdSeq({a[7:4], a[3:0] + 4'(i)}, 1'b1, 1);
    end
    // supervisor reset in mid-frame drops the transfer and its buffered byte
    devAddr(1'b0);
    `CHK(ack, 1'b1)
    mst_u.wrByte(8'h01, ack);
    `CHK(ack, 1'b1)
    mst_u.wrByte(~refMem[8'h01], ack);
    `CHK(ack, 1'b1)
    supRstIn = 1'b1;
    mst_u.w(6);
    mst_u.wrByte(8'h33, ack);
    `CHK(ack, 1'b0)
    mst_u.stop();
    supRstIn = 1'b0;
    mst_u.w(4);
    pageWr(8'h00, 1, 1'b1);
    rdSeq(8'h00, 1'b1, 2);
    complete_run();
  end

  // whole run needs under 30k clocks; stop at 80k
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule : tb_ee_access
